//--- tb/lpm_chk.sv
// port assertions for the window control block
`timescale 1ns/1ps
module lpm_chk
  import lpm_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        out_valid,
  input wire logic [31:0] out_addr,
  input wire logic        out_io,
  input wire logic        rd_fifo_full,
  input wire logic [6:0]  wf_count,
  input wire logic        burst_wr_start,
  input wire logic        release_bus,
  input wire logic        irdy_hold_off,
  input wire logic        write_fifo_almost_full_out,
  input wire logic        pci_req_start
);
  logic [31:0] ctl;
  logic        busy;
  logic        af_exp;
  logic        go;
  logic        idle;
  assign af_exp = wf_count > ((7'({ctl[10], ctl[8:5]}) + 7'h01) << 1);
  assign idle = !busy || pci_req_start;
  assign go = burst_wr_start && idle && !ctl[9];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= '0;
    end else if (reg_wr && reg_addr == LPM_OFS_REMAP) begin
      ctl <= reg_wdata;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (idle && burst_wr_start) || (busy && !pci_req_start);
    end
  end
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  chk_full_release: assert property (
    rd_fifo_full && !ctl[4] |=> release_bus && !irdy_hold_off)
    else $error("full read fifo kept the bus");
  chk_full_hold: assert property (
    rd_fifo_full && ctl[4] |=> irdy_hold_off && !release_bus)
    else $error("full read fifo released the bus");
  chk_almost_full: assert property (
    $past(rst_n) |-> write_fifo_almost_full_out == $past(af_exp))
    else $error("almost full flag wrong");
  chk_req_now: assert property (
    go && ctl[15:14] == 2'b00 |-> ##2 pci_req_start)
    else $error("undelayed request late");
  chk_req_slow: assert property (
    go && ctl[15:14] == 2'b11 |=> !pci_req_start [*8] ##10 pci_req_start)
    else $error("16 clock delay wrong");
  chk_mwi_wait: assert property (
    ctl[9] && wf_count < 7'h08 |=> !pci_req_start)
    else $error("request before 8 words");
  chk_io_zero: assert property (
    out_valid && out_io && ctl[13] |-> out_addr[31:16] == 16'h0000)
    else $error("io upper address not zero");
  chk_win_enable: assert property (
    out_valid |-> (out_io ? ctl[1] : ctl[0]))
    else $error("word passed a disabled window");
  cover property (out_valid && out_io && ctl[13]);
  cover property (go && ctl[15:14] == 2'b11);
  cover property (rd_fifo_full && ctl[4]);
endmodule
bind lpm_window_ctrl lpm_chk lpm_chk_i (
  .clock                      (clock),
  .rst_n                      (rst_n),
  .reg_wr                     (reg_wr),
  .reg_addr                   (reg_addr),
  .reg_wdata                  (reg_wdata),
  .out_valid                  (out_valid),
  .out_addr                   (out_addr),
  .out_io                     (out_io),
  .rd_fifo_full               (rd_fifo_full),
  .wf_count                   (wf_count),
  .burst_wr_start             (burst_wr_start),
  .release_bus                (release_bus),
  .irdy_hold_off              (irdy_hold_off),
  .write_fifo_almost_full_out (write_fifo_almost_full_out),
  .pci_req_start              (pci_req_start)
);

//--- tb/lpm_sink.sv
// far-side model: accepts translated words, stalls at random
`timescale 1ns/1ps
module lpm_sink (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic stall,
  output logic      out_ready
);
  logic [15:0] lfsr;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lfsr      <= 16'hACE1;
      out_ready <= 1'b0;
    end else begin
      lfsr      <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      out_ready <= !stall || lfsr[1:0] == 2'b00;
    end
  end
endmodule

//--- tb/tb.sv
// self-checking bench for the window control block
`timescale 1ns/1ps
module tb;
  import lpm_pkg::*;
  localparam logic [15:0] RNG = 16'hFF00;
  localparam logic [15:0] IOB = 16'h0005;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr, reg_rd, req_valid, req_io, rd_done, rd_fifo_full;
  logic        burst_wr_start, out_ready, stall, reg_rvalid, req_ready;
  logic        out_valid, out_io, flush_rd_fifo, pf_stop, release_bus;
  logic        irdy_hold_off, pci_req_start, write_fifo_almost_full_out;
  logic        e_pf, e_fl;
  logic [1:0]  sz;
  logic [2:0]  e_st, s_st;
  logic [4:0]  pf_count, lim;
  logic [6:0]  wf_count;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, req_addr, out_addr, pf_addr, ctl, seed, r;
  logic [15:0] master_decode_range = RNG;
  logic [15:0] master_memory_base = 16'h1200;
  logic [31:0] cfg [4] = '{32'hAB00_0000, 32'hAB00_0003, 32'hAB00_2003,
                           32'hAB00_0001};
  logic [5:0]  dl [5] = '{6'h01, 6'h05, 6'h09, 6'h11, 6'h28};
  logic [31:0] rq[$];
  logic [32:0] oq[$];
  int          failures = 0;
  int          cmp_count = 0;
  int          n;
  always #5 clock = ~clock;
  lpm_window_ctrl lpm_window_ctrl_i (.*);
  lpm_sink lpm_sink_i (.*);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    if (!w) rq.push_back(d);
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic wait_req();
    n = 0;
    while (pci_req_start !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask
  task automatic rand_req();
    logic [31:0] a;
    logic        hit;
    logic [15:0] up;
    a = rnd();
    if (a[1]) a[31:16] = a[0] ? IOB : {8'h12, a[23:16]};
    hit = a[0] ? (ctl[1] && a[31:16] == IOB)
               : (ctl[0] && (a[31:16] & RNG) == 16'h1200);
    up = a[0] ? (ctl[13] ? 16'h0000 : ctl[31:16])
              : (ctl[31:16] & RNG) | (a[31:16] & ~RNG);
    if (hit) oq.push_back({a[0], up, a[15:0]});
    req_valid = 1'b1;
    req_io = a[0];
    req_addr = a;
    while (req_ready !== 1'b1) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1;
  endtask
  always @(posedge clock) begin
    if (reg_rvalid === 1'b1) begin
      chk(33'(reg_rdata), rq.size() ? 33'(rq.pop_front()) : 33'h1);
    end
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      chk({out_io, out_addr}, oq.size() ? oq.pop_front() : 33'h0);
    end
  end
  initial begin
    #100000;
    failures++;
    end_sim();
  end
  initial begin
    {reg_wr, reg_rd, req_valid, req_io, rd_done, rd_fifo_full} = '0;
    {burst_wr_start, stall, reg_addr, reg_wdata, req_addr} = '0;
    {pf_addr, pf_count, wf_count, ctl} = '0;
    seed = 32'h0001_1FB7;
    repeat (10) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    bus(1'b0, LPM_OFS_IO_BASE, 32'h0);
    bus(1'b0, LPM_OFS_REMAP, 32'h0);
    bus(1'b0, 8'h30, 32'h0);
    bus(1'b1, LPM_OFS_IO_BASE, 32'hFFFF_FFFF);
    bus(1'b0, LPM_OFS_IO_BASE, 32'hFFFF_0000);
    bus(1'b1, LPM_OFS_IO_BASE, {IOB, 16'h5A5A});
    bus(1'b0, LPM_OFS_IO_BASE, {IOB, 16'h0000});
    foreach (cfg[c]) begin
      ctl = cfg[c];
      stall = c[0];
      bus(1'b1, LPM_OFS_REMAP, ctl);
      bus(1'b0, LPM_OFS_REMAP, ctl);
      repeat (30) rand_req();
      req_valid = 1'b0;
      for (n = 0; oq.size() > 0 && n < 200; n++) @(posedge clock);
      #1;
      chk(33'(oq.size()), 33'h0);
    end
    for (int i = 0; i < 5; i++) begin
      ctl = (i < 4) ? 32'(i) << 14 : 32'h0000_0200;
      bus(1'b1, LPM_OFS_REMAP, ctl);
      burst_wr_start = 1'b1;
      @(posedge clock);
      #1;
      burst_wr_start = 1'b0;
      wait_req();
      chk(33'(n), 33'(dl[i]));
    end
    wf_count = 7'h08;
    wait_req();
    chk(33'(n < 4), 33'h1);
    for (int k = 0; k < 480; k++) begin
      if (k % 60 == 0) begin
        ctl = rnd();
        if (ctl[2]) ctl[4] = 1'b0;
        bus(1'b1, LPM_OFS_REMAP, ctl);
      end
      r = rnd();
      rd_done = r[0];
      rd_fifo_full = r[1];
      burst_wr_start = r[2] & r[3] & (k % 60 < 40);
      pf_addr = r[5] ? (r | 32'h0000_0FFC) : r;
      pf_count = 5'(r[10:6] % 17);
      wf_count = 7'(r[22:16] % 65);
      sz = {ctl[12], ctl[3]};
      lim = (sz == 2'b01) ? 5'h04 : (sz == 2'b10) ? 5'h08 : 5'h10;
      e_pf = (sz != 2'b00 && pf_count >= lim)
             || (ctl[11] && pf_addr[11:2] == 10'h3FF);
      e_fl = rd_done && !(ctl[2] && sz == 2'b00);
      e_st = {rd_fifo_full && !ctl[4], rd_fifo_full && ctl[4],
              wf_count > 7'(2 * ({ctl[10], ctl[8:5]} + 1))};
      @(posedge clock);
      #1;
      chk(33'({flush_rd_fifo, pf_stop}), 33'({e_fl, e_pf}));
      s_st = {release_bus, irdy_hold_off, write_fifo_almost_full_out};
      chk(33'(s_st), 33'(e_st));
    end
    end_sim();
  end
endmodule

//--- verilog/lpm_buf2.sv
// two-entry valid/ready buffer, head entry held in a flip-flop
`timescale 1ns/1ps
module lpm_buf2 #(
  parameter int W = 33
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic      [W-1:0] out_data,
  input  wire logic         out_ready
);
  logic [W-1:0] ent1;
  logic [1:0]   cnt;
  logic [1:0]   next_cnt;
  logic         push;
  logic         pop;

  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;

  always_comb begin
    next_cnt = cnt;
    if (push && !pop) begin
      next_cnt = cnt + 2'd1;
    end else if (pop && !push) begin
      next_cnt = cnt - 2'd1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt       <= 2'd0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      cnt       <= next_cnt;
      in_ready  <= (next_cnt != 2'd2);
      out_valid <= (next_cnt != 2'd0);
    end
  end

  // head moves up from entry 1 on a pop, new word lands in the first free
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_data <= '0;
      ent1     <= '0;
    end else begin
      if (pop) begin
        out_data <= (cnt == 2'd2) ? ent1 : in_data;
      end else if (push && cnt == 2'd0) begin
        out_data <= in_data;
      end
      if (push && ((cnt == 2'd1 && !pop) || (cnt == 2'd2 && pop))) begin
        ent1 <= in_data;
      end
    end
  end
endmodule

//--- verilog/lpm_pkg.sv
// constants for the local-to-pci master window control block
package lpm_pkg;
  localparam logic [7:0]  LPM_OFS_IO_BASE  = 8'h24;
  localparam logic [7:0]  LPM_OFS_REMAP    = 8'h28;
  localparam logic [31:0] LPM_IO_BASE_RST  = 32'h0000_0000;
  localparam logic [31:0] LPM_REMAP_RST    = 32'h0000_0000;
  localparam logic [31:0] LPM_IO_BASE_WMSK = 32'hFFFF_0000;
  // field positions of master_pci_remap_ctrl
  localparam int LPM_B_MEM_EN     = 0;
  localparam int LPM_B_IO_EN      = 1;
  localparam int LPM_B_READ_AHEAD = 2;
  localparam int LPM_B_PF_LO      = 3;
  localparam int LPM_B_READ_MODE  = 4;
  localparam int LPM_B_AF_LO      = 5;
  localparam int LPM_B_AF_HI4     = 8;
  localparam int LPM_B_MWI        = 9;
  localparam int LPM_B_AF_TOP     = 10;
  localparam int LPM_B_PF_LIMIT   = 11;
  localparam int LPM_B_PF_HI      = 12;
  localparam int LPM_B_IO_REMAP   = 13;
  localparam int LPM_B_DLY_LO     = 14;
  localparam int LPM_B_DLY_HI     = 15;
  // prefetch depths in words
  localparam logic [4:0] LPM_PF_WORDS_1 = 5'h04;
  localparam logic [4:0] LPM_PF_WORDS_2 = 5'h08;
  localparam logic [4:0] LPM_PF_WORDS_3 = 5'h10;
  // write request delays in pci clocks (pci clock is the block clock)
  localparam int         LPM_CLK_MHZ    = 100;
  localparam int         LPM_PCI_MHZ    = 100;
  localparam logic [4:0] LPM_DLY_1 = 5'(4 * LPM_CLK_MHZ / LPM_PCI_MHZ);
  localparam logic [4:0] LPM_DLY_2 = 5'(8 * LPM_CLK_MHZ / LPM_PCI_MHZ);
  localparam logic [4:0] LPM_DLY_3 = 5'(16 * LPM_CLK_MHZ / LPM_PCI_MHZ);
  // memory write and invalidate waits for this many words
  localparam logic [6:0] LPM_MWI_WORDS  = 7'h08;
  localparam int         LPM_XLAT_W     = 33;
  typedef enum logic [1:0] {LPM_W_IDLE, LPM_W_DELAY, LPM_W_WAIT} lpm_wr_t;
endpackage

//--- verilog/lpm_window_ctrl.sv
// local-to-pci master window decode, remap and path control
`timescale 1ns/1ps
module lpm_window_ctrl
  import lpm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic [15:0] master_decode_range,
  input  wire logic [15:0] master_memory_base,
  input  wire logic        req_valid,
  input  wire logic [31:0] req_addr,
  input  wire logic        req_io,
  output logic             req_ready,
  output logic             out_valid,
  output logic      [31:0] out_addr,
  output logic             out_io,
  input  wire logic        out_ready,
  input  wire logic        rd_done,
  input  wire logic        rd_fifo_full,
  input  wire logic [31:0] pf_addr,
  input  wire logic [4:0]  pf_count,
  input  wire logic [6:0]  wf_count,
  input  wire logic        burst_wr_start,
  output logic             flush_rd_fifo,
  output logic             pf_stop,
  output logic             release_bus,
  output logic             irdy_hold_off,
  output logic             write_fifo_almost_full_out,
  output logic             pci_req_start
);
  logic [31:0] master_io_cfg_base;
  logic [31:0] master_pci_remap_ctrl;
  logic [15:0] remap_hi;
  logic [1:0]  pf_size;
  logic [1:0]  wr_dly_sel;
  logic [4:0]  af_thr;
  logic [4:0]  pf_limit_words;
  logic        mem_hit;
  logic        io_hit;
  logic [31:0] xl_addr;
  logic        in_valid;
  logic        buf_ready;
  logic [LPM_XLAT_W-1:0] buf_out;
  lpm_wr_t     wr_state;
  logic [4:0]  wr_cnt;
  logic [4:0]  wr_dly;

  assign remap_hi   = master_pci_remap_ctrl[31:16];
  assign pf_size    = {master_pci_remap_ctrl[LPM_B_PF_HI],
                       master_pci_remap_ctrl[LPM_B_PF_LO]};
  assign wr_dly_sel = master_pci_remap_ctrl[LPM_B_DLY_HI:LPM_B_DLY_LO];
  assign af_thr     = {master_pci_remap_ctrl[LPM_B_AF_TOP],
                       master_pci_remap_ctrl[LPM_B_AF_HI4:LPM_B_AF_LO]};

  // register writes; low half of io base is fixed at zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      master_io_cfg_base    <= LPM_IO_BASE_RST;
      master_pci_remap_ctrl <= LPM_REMAP_RST;
    end else if (reg_wr) begin
      if (reg_addr == LPM_OFS_IO_BASE) begin
        master_io_cfg_base <= reg_wdata & LPM_IO_BASE_WMSK;
      end
      if (reg_addr == LPM_OFS_REMAP) begin
        master_pci_remap_ctrl <= reg_wdata;
      end
    end
  end

  // register reads answer one cycle later, unmapped reads give zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        unique case (reg_addr)
          LPM_OFS_IO_BASE: reg_rdata <= master_io_cfg_base;
          LPM_OFS_REMAP:   reg_rdata <= master_pci_remap_ctrl;
          default:         reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // address decode and translation
  assign mem_hit = master_pci_remap_ctrl[LPM_B_MEM_EN] &&
                   !req_io &&
                   ((req_addr[31:16] & master_decode_range) ==
                    master_memory_base);
  assign io_hit  = master_pci_remap_ctrl[LPM_B_IO_EN] &&
                   req_io &&
                   (req_addr[31:16] ==
                    master_io_cfg_base[31:16]);

  always_comb begin
    xl_addr = req_addr;
    if (req_io) begin
      xl_addr[31:16] = master_pci_remap_ctrl[LPM_B_IO_REMAP] ?
                       16'h0000 : remap_hi;
    end else begin
      xl_addr[31:16] = (remap_hi & master_decode_range) |
                       (req_addr[31:16] & ~master_decode_range);
    end
  end

  // misses are taken and dropped; hits queue for the pci side
  assign in_valid  = req_valid && (mem_hit || io_hit);
  assign req_ready = buf_ready;
  assign out_io    = buf_out[LPM_XLAT_W-1];
  assign out_addr  = buf_out[31:0];

  lpm_buf2 #(
    .W (LPM_XLAT_W)
  ) u_buf (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (in_valid),
    .in_data   ({req_io, xl_addr}),
    .in_ready  (buf_ready),
    .out_valid (out_valid),
    .out_data  (buf_out),
    .out_ready (out_ready)
  );

  // read fifo handling and prefetch limits
  always_comb begin
    unique case (pf_size)
      2'b00: pf_limit_words = 5'h00;
      2'b01: pf_limit_words = LPM_PF_WORDS_1;
      2'b10: pf_limit_words = LPM_PF_WORDS_2;
      2'b11: pf_limit_words = LPM_PF_WORDS_3;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flush_rd_fifo <= 1'b0;
      pf_stop       <= 1'b0;
      release_bus   <= 1'b0;
      irdy_hold_off <= 1'b0;
    end else begin
      flush_rd_fifo <= rd_done &&
        !(master_pci_remap_ctrl[LPM_B_READ_AHEAD] && pf_size == 2'b00);
      pf_stop <= ((pf_size != 2'b00) &&
                  (pf_count >= pf_limit_words)) ||
                 (master_pci_remap_ctrl[LPM_B_PF_LIMIT] &&
                  (pf_addr[11:2] == 10'h3FF));
      release_bus   <= rd_fifo_full &&
                       !master_pci_remap_ctrl[LPM_B_READ_MODE];
      irdy_hold_off <= rd_fifo_full &&
                       master_pci_remap_ctrl[LPM_B_READ_MODE];
    end
  end

  // write fifo almost full threshold
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      write_fifo_almost_full_out <= 1'b0;
    end else begin
      write_fifo_almost_full_out <=
        ({1'b0, wf_count} > ({3'b000, af_thr} + 8'd1) * 8'd2);
    end
  end

  // delayed write request and write-and-invalidate gating
  always_comb begin
    unique case (wr_dly_sel)
      2'b00: wr_dly = 5'h00;
      2'b01: wr_dly = LPM_DLY_1;
      2'b10: wr_dly = LPM_DLY_2;
      2'b11: wr_dly = LPM_DLY_3;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_state      <= LPM_W_IDLE;
      wr_cnt        <= 5'h00;
      pci_req_start <= 1'b0;
    end else begin
      pci_req_start <= 1'b0;
      unique case (wr_state)
        LPM_W_IDLE: begin
          if (burst_wr_start) begin
            wr_cnt   <= wr_dly;
            wr_state <= (wr_dly == 5'h00) ? LPM_W_WAIT : LPM_W_DELAY;
          end
        end
        LPM_W_DELAY: begin
          wr_cnt <= wr_cnt - 5'd1;
          if (wr_cnt == 5'd1) begin
            wr_state <= LPM_W_WAIT;
          end
        end
        LPM_W_WAIT: begin
          if (!master_pci_remap_ctrl[LPM_B_MWI] ||
              wf_count >= LPM_MWI_WORDS) begin
            pci_req_start <= 1'b1;
            wr_state      <= LPM_W_IDLE;
          end
        end
        default: begin
          wr_state <= LPM_W_IDLE;
        end
      endcase
    end
  end
endmodule
